// >>> hdl/adpd_pkg.sv
// constants, types and register map shared by the converter power-down control block
package adpd_pkg;

    // ****************************************************************
    // clock and conversion timing
    // ****************************************************************
    localparam int           CLK_PERIOD_NS    = 5;
    localparam int           INT_CONV_TIME_NS = 10000;
    localparam logic [11:0]  INT_CONV_CYCLES  = 12'(INT_CONV_TIME_NS / CLK_PERIOD_NS);
    localparam logic [3:0]   EXT_CONV_EDGES   = 4'hC;
    localparam logic [3:0]   CTRL_BITS        = 4'h8;

    // host-side waits, kept for the bench
    localparam int           PWRUP_FAST_INT_US   = 5;
    localparam int           PWRUP_FULL_INT_US   = 300;
    localparam int           PWRUP_NOBUF_US      = 2;
    localparam int           RATE_INT_COMP_KSPS  = 26;
    localparam int           RATE_EXT_COMP_KSPS  = 133;
    localparam int           PWRUP_SMALL_CAP_MS  = 20;
    localparam int           PWRUP_LARGE_CAP_MS  = 200;
    localparam int           FAST_WAKE_EXT_US    = 50;
    localparam int           REF_SETTLE_MS       = 2;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0]   ADDR_SAMPLE      = 8'h00;
    localparam logic [7:0]   ADDR_STATUS      = 8'h04;
    localparam logic [7:0]   ADDR_RESULT      = 8'h08;
    localparam logic [11:0]  SAMPLE_RESET     = 12'h0_000;
    localparam logic [1:0]   MODE_RESET       = 2'h2;
    localparam logic [1:0]   RESP_OKAY        = 2'h0;
    localparam logic [1:0]   RESP_SLVERR      = 2'h2;

    // power-mode field encodings
    localparam logic [1:0]   MODE_DEEP        = 2'h0;
    localparam logic [1:0]   MODE_LIGHT       = 2'h1;

    typedef enum logic [3:0] {
        ST_DEEP  = 4'h1,
        ST_LIGHT = 4'h2,
        ST_IDLE  = 4'h4,
        ST_CONV  = 4'h8
    } adpd_state_e;

    typedef enum logic [1:0] {
        SEL_SAMPLE = 2'h0,
        SEL_STATUS = 2'h1,
        SEL_RESULT = 2'h2,
        SEL_NONE   = 2'h3
    } adpd_sel_e;

    typedef struct packed {
        logic sclk;
        logic csN;
        logic din;
        logic hwPowerDownPin;
        logic hwPowerDownFloat;
    } adpd_pins_s;

    // idle pin levels loaded into the synchroniser, so reset shows no false shutdown or select
    localparam adpd_pins_s   PINS_IDLE        = '{sclk: 1'b0, csN: 1'b1, din: 1'b0,
                                                  hwPowerDownPin: 1'b1, hwPowerDownFloat: 1'b0};

endpackage : adpd_pkg

// >>> hdl/adpd_power_ctrl.sv
// power-down and wake control of the serial converter, with an AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - the two last control-byte bits pick deep sleep, light sleep, internal clock or external clock mode.
// - a low shutdown pin forces full shutdown at any time, over whatever the mode bits ask.
// - in software sleep the serial port still shifts bits while no conversion runs.
// - a sleep request lets the running conversion finish in the previous clock mode before sleeping.
// - in internal clock mode a finished result can still be shifted out after entering sleep.
// - the first one seen on the data input is the start bit and wakes the converter.
// - a high mode bit of one keeps the converter awake after converting, zero sleeps after one conversion.
// - a low shutdown pin drops into deep sleep at once and abandons any running conversion.
// - the shutdown pin high enables internal compensation, floating enables external, low powers down.
// - the mode bits are bits 1 and 0 of the eight-bit byte, and conversion starts at the next falling clock.
module adpd_power_ctrl (
    input  wire logic               clock,
    input  wire logic               resetn,
    input  wire adpd_pkg::adpd_pins_s linkPins,
    output logic                    doutData,
    output logic                    doutOe,
    output logic                    deepSleepState,
    output logic                    lightSleepState,
    output logic                    convBusy,
    output logic                    compExternal,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);

    // ****************************************************************
    // pin synchronisation and link clock edges
    // ****************************************************************
    adpd_pkg::adpd_pins_s  pinsS;
    logic                  sclkPrevQ;
    logic                  sclkRise;
    logic                  sclkFall;
    logic                  pinLow;

    adpd_sync2 #(.WIDTH($bits(adpd_pkg::adpd_pins_s)), .RESET_VALUE(adpd_pkg::PINS_IDLE)) u_sync (
        .clock   (clock),
        .resetn  (resetn),
        .asyncIn (linkPins),
        .syncOut (pinsS)
    );

    always_ff @(posedge clock) begin
        if (!resetn) sclkPrevQ <= 1'b0;
        else         sclkPrevQ <= pinsS.sclk;
    end

    assign sclkRise = pinsS.sclk & ~sclkPrevQ;
    assign sclkFall = ~pinsS.sclk & sclkPrevQ;
    // floating pin reads as enabled, only a driven low shuts down
    assign pinLow   = ~pinsS.hwPowerDownPin & ~pinsS.hwPowerDownFloat;

    // ****************************************************************
    // control byte reception
    // ****************************************************************
    adpd_pkg::adpd_state_e stateQ;
    logic [3:0]            rxCntQ;
    logic [7:0]            rxByteQ;
    logic                  startBit;
    logic                  convStart;
    logic                  rxOpen;

    // the port keeps shifting in any sleep state; only a deselect or a running conversion closes it
    assign rxOpen    = ~pinsS.csN & (stateQ != adpd_pkg::ST_CONV);
    assign startBit  = rxOpen & sclkRise & (rxCntQ == 4'h0) & pinsS.din;
    assign convStart = rxOpen & sclkFall & (rxCntQ == adpd_pkg::CTRL_BITS) & ~pinLow;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            rxCntQ  <= 4'h0;
            rxByteQ <= 8'h00;
        end else if (!rxOpen || convStart) begin
            rxCntQ  <= 4'h0;
        end else if (sclkRise && rxCntQ != adpd_pkg::CTRL_BITS) begin
            if (rxCntQ != 4'h0 || pinsS.din) begin
                rxCntQ  <= rxCntQ + 4'h1;
                rxByteQ <= {rxByteQ[6:0], pinsS.din};
            end
        end
    end

    // ****************************************************************
    // held mode bits and clock mode
    // ****************************************************************
    logic [1:0] modeQ;
    logic       clkExtQ;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            modeQ   <= adpd_pkg::MODE_RESET;
            clkExtQ <= 1'b0;
        end else if (convStart) begin
            modeQ <= rxByteQ[1:0];
            // a sleep request keeps the previous clock mode for this conversion
            if (rxByteQ[1]) clkExtQ <= rxByteQ[0];
        end
    end

    // ****************************************************************
    // power state machine and conversion timing
    // ****************************************************************
    logic [11:0] convCntQ;
    logic        convDone;
    logic [11:0] sampleQ;
    logic [11:0] resultQ;
    logic [11:0] doutShQ;

    assign convDone = (stateQ == adpd_pkg::ST_CONV) &
        (clkExtQ ? (sclkFall && convCntQ == {8'h00, adpd_pkg::EXT_CONV_EDGES} - 12'h001)
                 : (convCntQ == adpd_pkg::INT_CONV_CYCLES - 12'h001));

    always_ff @(posedge clock) begin
        if (!resetn) begin
            stateQ <= adpd_pkg::ST_IDLE;
        end else if (pinLow) begin
            stateQ <= adpd_pkg::ST_DEEP;
        end else begin
            case (stateQ)
                adpd_pkg::ST_DEEP,
                adpd_pkg::ST_LIGHT: begin
                    if (startBit) stateQ <= adpd_pkg::ST_IDLE;
                end
                adpd_pkg::ST_IDLE: begin
                    if (convStart) stateQ <= adpd_pkg::ST_CONV;
                end
                adpd_pkg::ST_CONV: begin
                    if (convDone) begin
                        if (modeQ[1])                        stateQ <= adpd_pkg::ST_IDLE;
                        else if (modeQ == adpd_pkg::MODE_LIGHT) stateQ <= adpd_pkg::ST_LIGHT;
                        else                                 stateQ <= adpd_pkg::ST_DEEP;
                    end
                end
                default: stateQ <= adpd_pkg::ST_DEEP;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn || pinLow || stateQ != adpd_pkg::ST_CONV) begin
            convCntQ <= 12'h000;
        end else if (!clkExtQ || sclkFall) begin
            convCntQ <= convCntQ + 12'h001;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) resultQ <= 12'h000;
        else if (convDone && !pinLow) resultQ <= sampleQ;
    end

    // result stays shiftable after the drop into sleep
    always_ff @(posedge clock) begin
        if (!resetn) begin
            doutShQ <= 12'h000;
        end else if (convDone && !pinLow) begin
            doutShQ <= sampleQ;
        end else if (sclkFall && !pinsS.csN) begin
            doutShQ <= {doutShQ[10:0], 1'b0};
        end
    end

    assign doutData        = doutShQ[11];
    assign doutOe          = ~pinsS.csN;
    assign deepSleepState  = stateQ == adpd_pkg::ST_DEEP;
    assign lightSleepState = stateQ == adpd_pkg::ST_LIGHT;
    assign convBusy        = stateQ == adpd_pkg::ST_CONV;
    assign compExternal    = pinsS.hwPowerDownFloat;

    // ****************************************************************
    // AXI4-Lite register slave
    // ****************************************************************
    function automatic adpd_pkg::adpd_sel_e regSel(input logic [7:0] addr);
        case (addr)
            adpd_pkg::ADDR_SAMPLE: regSel = adpd_pkg::SEL_SAMPLE;
            adpd_pkg::ADDR_STATUS: regSel = adpd_pkg::SEL_STATUS;
            adpd_pkg::ADDR_RESULT: regSel = adpd_pkg::SEL_RESULT;
            default:               regSel = adpd_pkg::SEL_NONE;
        endcase
    endfunction : regSel

    logic        awHeldQ;
    logic        wHeldQ;
    logic [7:0]  awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0]  wStrbQ;
    logic        doWrite;

    assign s_axi_awready = ~awHeldQ & ~s_axi_bvalid;
    assign s_axi_wready  = ~wHeldQ & ~s_axi_bvalid;
    assign doWrite       = awHeldQ & wHeldQ & ~s_axi_bvalid;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            awHeldQ <= 1'b0;
            wHeldQ  <= 1'b0;
            awAddrQ <= 8'h00;
            wDataQ  <= 32'h0000_0000;
            wStrbQ  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeldQ <= 1'b1;
                awAddrQ <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeldQ <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeldQ <= 1'b1;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeldQ <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            sampleQ      <= adpd_pkg::SAMPLE_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= adpd_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= adpd_pkg::RESP_OKAY;
            case (regSel(awAddrQ))
                adpd_pkg::SEL_SAMPLE: begin
                    if (wStrbQ[0]) sampleQ[7:0]  <= wDataQ[7:0];
                    if (wStrbQ[1]) sampleQ[11:8] <= wDataQ[11:8];
                end
                adpd_pkg::SEL_STATUS,
                adpd_pkg::SEL_RESULT: ;
                default: s_axi_bresp <= adpd_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= adpd_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= adpd_pkg::RESP_OKAY;
            case (regSel(s_axi_araddr))
                adpd_pkg::SEL_SAMPLE: s_axi_rdata <= {20'h0_0000, sampleQ};
                adpd_pkg::SEL_STATUS: s_axi_rdata <= {22'h0, pinLow, compExternal,
                                                      clkExtQ, modeQ, stateQ, 1'b0};
                adpd_pkg::SEL_RESULT: s_axi_rdata <= {20'h0_0000, resultQ};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= adpd_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : adpd_power_ctrl
`default_nettype wire

// >>> hdl/adpd_sync2.sv
// two-flop synchroniser for the asynchronous link and shutdown pins
`timescale 1ns/100ps
`default_nettype none
module adpd_sync2 #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] metaQ;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            metaQ   <= RESET_VALUE;
            syncOut <= RESET_VALUE;
        end else begin
            metaQ   <= asyncIn;
            syncOut <= metaQ;
        end
    end
endmodule : adpd_sync2
`default_nettype wire

// >>> tb/adpd_host_link.sv
// serial host model that frames control bytes and clocks results back
`timescale 1ns/100ps
`default_nettype none
module adpd_host_link (
    input  wire logic clock,
    input  wire logic dout,
    output var logic  sclk,
    output var logic  csN,
    output var logic  din
);
    // 16 system cycles per half period gives the 160 ns serial clock
    localparam int HALF = 16;
    // frames start at least one 26 ksps sample period apart; that also leaves far more than the 5 us
    // light-sleep power-up before a result is trusted, and no result after a deep-sleep wake is trusted
    localparam int RATE_GAP = 1_000_000 / (adpd_pkg::RATE_INT_COMP_KSPS * adpd_pkg::CLK_PERIOD_NS);
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        din = 1'b1;
    end
    task automatic frame(input logic [7:0] ctrl, input int waitCyc, input int nClk, output logic [23:0] rx);
        rx = '0;
        repeat (RATE_GAP) @(posedge clock);
        csN <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            din <= ctrl[7-i];
            repeat (HALF) @(posedge clock);
            sclk <= 1'b1;
            repeat (HALF) @(posedge clock);
            sclk <= 1'b0;
        end
        // zeros while reading, so no new start bit is seen
        din <= 1'b0;
        repeat (waitCyc) @(posedge clock);
        for (int i = 0; i < nClk; i++) begin
            repeat (HALF) @(posedge clock);
            sclk <= 1'b1;
            rx = {rx[22:0], dout};
            repeat (HALF) @(posedge clock);
            sclk <= 1'b0;
        end
        repeat (HALF) @(posedge clock);
        csN <= 1'b1;
        din <= 1'b1;
    endtask : frame
endmodule : adpd_host_link
`default_nettype wire

// >>> tb/adpd_power_ctrl_bench.sv
// self-checking bench for the converter power-down control block
`timescale 1ns/100ps
`default_nettype none
module adpd_power_ctrl_bench;
    typedef struct {
        logic [1:0]  mode;
        int          skip;
        logic [1:0]  sleep;
        logic [11:0] smp;
    } adpd_row_s;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        pdPin = 1'b1;
    logic        pdFloat = 1'b0;
    wire logic   hSclk, hCsN, hDin;
    adpd_pkg::adpd_pins_s linkPins;
    logic        doutData, doutOe, deepSleepState, lightSleepState, convBusy, compExternal;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int          failures = 0;
    int          nTests = 0;
    // external rows read the result twelve falls later than internal ones
    adpd_row_s   rows [4] = '{'{2'b10, 0, 2'b00, 12'hA5C}, '{2'b01, 0, 2'b01, 12'h3C6},
                              '{2'b11, 12, 2'b00, 12'h801}, '{2'b00, 12, 2'b10, 12'h7FE}};
    assign linkPins = {hSclk, hCsN, hDin, pdPin, pdFloat};
    always #2.5 clock = ~clock;
    adpd_power_ctrl u_dut (.*);
    adpd_host_link u_host (.clock(clock), .dout(doutData), .sclk(hSclk), .csN(hCsN), .din(hDin));
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        failures++;
        tally_and_finish();
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        failures++;
        tally_and_finish();
    endtask : axr
    initial begin
        logic [1:0]  r;
        logic [31:0] d;
        logic [23:0] rx;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        chk({deepSleepState, lightSleepState, convBusy, doutOe}, 0);
        axr(adpd_pkg::ADDR_STATUS, d, r);
        chk(d, {22'h0, 3'h0, adpd_pkg::MODE_RESET, 4'h4, 1'b0});
        axr(8'h0C, d, r);
        chk({r, d[29:0]}, {adpd_pkg::RESP_SLVERR, 30'h0});
        axw(8'h10, 32'h0000_0000, r);
        chk(r, adpd_pkg::RESP_SLVERR);
        $display("reset and map test done");
        foreach (rows[i]) begin
            axw(adpd_pkg::ADDR_SAMPLE, {20'h0_0000, rows[i].smp}, r);
            chk(r, adpd_pkg::RESP_OKAY);
            u_host.frame({6'h20, rows[i].mode}, 2100, 24, rx);
            chk(12'(rx >> (12 - rows[i].skip)), rows[i].smp);
            chk({deepSleepState, lightSleepState}, rows[i].sleep);
            axr(adpd_pkg::ADDR_STATUS, d, r);
            chk(d[6:5], rows[i].mode);
            $display("mode row %0d done", i);
        end
        axw(adpd_pkg::ADDR_SAMPLE, 32'h0000_0123, r);
        u_host.frame(8'h82, 200, 0, rx);
        chk(convBusy, 1'b1);
        pdPin <= 1'b0;
        repeat (5) @(posedge clock);
        chk({deepSleepState, convBusy}, 2'b10);
        u_host.frame(8'h82, 2100, 0, rx);
        chk({deepSleepState, convBusy}, 2'b10);
        axr(adpd_pkg::ADDR_RESULT, d, r);
        chk(d, {20'h0_0000, rows[3].smp});
        // no conversion runs with external compensation, so its capacitor waits never arise
        pdPin <= 1'b1;
        pdFloat <= 1'b1;
        repeat (5) @(posedge clock);
        axr(adpd_pkg::ADDR_STATUS, d, r);
        chk({compExternal, d[9:8]}, 3'b101);
        $display("shutdown test done");
        tally_and_finish();
    end
endmodule : adpd_power_ctrl_bench
`default_nettype wire

// >>> tb/adpd_power_ctrl_sva.sv
// port-level assertions for the converter power-down control block
`timescale 1ns/100ps
`default_nettype none
module adpd_power_ctrl_sva (
    input wire logic                 clock,
    input wire logic                 resetn,
    input wire adpd_pkg::adpd_pins_s linkPins,
    input wire logic                 doutOe,
    input wire logic                 deepSleepState,
    input wire logic                 lightSleepState,
    input wire logic                 convBusy,
    input wire logic                 compExternal,
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire logic [1:0]           s_axi_bresp,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic [31:0]          s_axi_rdata,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // ********
    // power state
    // ********
    // four edges cover the two-flop synchroniser plus the state update
    shutdown_deep_a: assert property ((!linkPins.hwPowerDownPin && !linkPins.hwPowerDownFloat)[*4]
        |-> deepSleepState && !convBusy)
        else $error("shutdown pin low but not in deep sleep");
    single_state_a: assert property ($onehot0({deepSleepState, lightSleepState, convBusy}))
        else $error("more than one power state at once");
    float_comp_a: assert property (linkPins.hwPowerDownFloat[*3] |-> compExternal)
        else $error("floating shutdown pin without external compensation");
    cs_quiet_a: assert property (linkPins.csN[*3] |-> !doutOe)
        else $error("serial output driven while deselected");
    // ********
    // register bus
    // ********
    // both items are held one edge, and the response is registered at the next
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
endmodule : adpd_power_ctrl_sva
bind adpd_power_ctrl adpd_power_ctrl_sva u_sva (.*);
`default_nettype wire
